/* src/rtcal_top.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - alarm high bits 3:0 take writes only when alarm or clock enable clear.
// - alarm high bits 3:0 read back at any time.
// - alarm high bits 7:4 ignore writes and read as zero.
// - alarm low reads always; writes need busy clear and an enable clear.
// - alarm fires only at subsecond rollover when twenty seconds bits match.
// - alarm registers survive reset; only supply loss disturbs them.
// - subsecond counts 256 Hz ticks; its rollover advances the seconds.
module rtcal_top
  import rtcal_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        osc_32k,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq
);

  rtcal_ctl_s ctl_r;
  rtcal_ctl_s ctl_nxt;
  rtcal_bak_s bak_r;
  rtcal_bak_s bak_nxt;

  logic       addr_ok;
  logic [5:0] addr_idx;
  logic       osc_edge;
  logic       tick;
  logic       busy;
  logic       alm_open;
  logic       wr_alm_hi;
  logic       wr_alm_lo;
  logic       cnt_open;
  logic       rollover;
  logic       trig;
  logic       flag_clr;
  logic [31:0] sec_inc;

  // twenty-bit compare of alarm pair against seconds
  function automatic logic alarm_match(input rtcal_bak_s b,
                                       input logic [31:0] s);
    alarm_match = ({b.alm_hi, b.alm_lo} == s[19:0]);
  endfunction

  // aligned word decode inside the low 256 bytes
  function automatic logic word_ok(input logic [31:0] a);
    word_ok = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00);
  endfunction

  // data-phase write hit on one register
  function automatic logic wr_hit(input rtcal_ctl_s c,
                                  input logic [5:0] idx);
    wr_hit = c.dp_wr && (c.dp_idx == idx);
  endfunction

  // read mux; unmapped words read zero
  function automatic logic [31:0] rd_word(input logic [5:0] idx,
                                          input rtcal_ctl_s c,
                                          input rtcal_bak_s b);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == IDX_SUBSEC) begin
      w[7:0] = b.sub;
    end else if (idx == IDX_SEC_HI) begin
      w[15:0] = b.sec[31:16];
    end else if (idx == IDX_SEC_LO) begin
      w[15:0] = b.sec[15:0];
    end else if (idx == IDX_ALM_HI) begin
      w[3:0] = b.alm_hi; // upper bits stay zero
    end else if (idx == IDX_ALM_LO) begin
      w[15:0] = b.alm_lo;
    end else if (idx == IDX_CTRL) begin
      w[CTRL_CCE_BIT] = c.cce;
      w[CTRL_ADE_BIT] = c.ade;
    end else if (idx == IDX_STAT) begin
      w[STAT_BUSY_BIT] = (c.busy_cnt != 3'h0);
    end else if (idx == IDX_ISTAT) begin
      w[IRQ_TOD_BIT] = c.tod_flag;
    end else if (idx == IDX_IMASK) begin
      w[IRQ_TOD_BIT] = c.tod_mask;
    end
    rd_word = w;
  endfunction

  // address phase qualification; only word singles expected
  assign addr_ok  = hsel && hready && (htrans == HTRANS_NSEQ) &&
                    word_ok(haddr);
  assign addr_idx = haddr[7:2];

  // oscillator edge after two-flop sync, then divide by 128
  assign osc_edge = ctl_r.osc_s2 && !ctl_r.osc_s3;
  assign tick     = osc_edge && (ctl_r.div == DIV_LAST);

  // write gating terms
  assign busy      = (ctl_r.busy_cnt != 3'h0);
  assign alm_open  = !ctl_r.ade || !ctl_r.cce;
  assign wr_alm_hi = wr_hit(ctl_r, IDX_ALM_HI) && alm_open;
  assign wr_alm_lo = wr_hit(ctl_r, IDX_ALM_LO) && alm_open &&
                     !busy;
  assign cnt_open  = !ctl_r.cce && !busy;

  // counter chain; alarm looks at the seconds value being entered
  assign sec_inc  = bak_r.sec + 32'h0000_0001;
  assign rollover = tick && ctl_r.cce && (bak_r.sub == SUB_LAST);
  assign trig     = rollover && alarm_match(bak_r, sec_inc);
  assign flag_clr = wr_hit(ctl_r, IDX_ISTAT) && hwdata[IRQ_TOD_BIT];

  // next-state logic for both state groups
  always_comb begin
    ctl_nxt = ctl_r;
    bak_nxt = bak_r;
    // sync chain: s1 feeds s2 only
    ctl_nxt.osc_s1 = osc_32k;
    ctl_nxt.osc_s2 = ctl_r.osc_s1;
    ctl_nxt.osc_s3 = ctl_r.osc_s2;
    if (osc_edge) begin
      ctl_nxt.div = ctl_r.div + 7'h01;
    end
    // subsecond and seconds advance
    if (tick && ctl_r.cce) begin
      bak_nxt.sub = bak_r.sub + 8'h01;
      if (bak_r.sub == SUB_LAST) begin
        bak_nxt.sec = sec_inc;
      end
    end
    // busy counts down after a counter load
    if (busy) begin
      ctl_nxt.busy_cnt = ctl_r.busy_cnt - 3'h1;
    end
    // counter loads need the clock stopped and no load in flight
    if (cnt_open && wr_hit(ctl_r, IDX_SUBSEC)) begin
      bak_nxt.sub      = hwdata[7:0];
      ctl_nxt.busy_cnt = BUSY_CYCLES;
    end else if (cnt_open && wr_hit(ctl_r, IDX_SEC_HI)) begin
      bak_nxt.sec[31:16] = hwdata[15:0];
      ctl_nxt.busy_cnt   = BUSY_CYCLES;
    end else if (cnt_open && wr_hit(ctl_r, IDX_SEC_LO)) begin
      bak_nxt.sec[15:0] = hwdata[15:0];
      ctl_nxt.busy_cnt  = BUSY_CYCLES;
    end
    // alarm pair; only the low nibble of the high word is kept
    if (wr_alm_hi) begin
      bak_nxt.alm_hi = hwdata[3:0];
    end
    if (wr_alm_lo) begin
      bak_nxt.alm_lo = hwdata[15:0];
    end
    // control and mask are always writable
    if (wr_hit(ctl_r, IDX_CTRL)) begin
      ctl_nxt.cce = hwdata[CTRL_CCE_BIT];
      ctl_nxt.ade = hwdata[CTRL_ADE_BIT];
    end
    if (wr_hit(ctl_r, IDX_IMASK)) begin
      ctl_nxt.tod_mask = hwdata[IRQ_TOD_BIT];
    end
    // sticky flag: a firing in the clear cycle is kept
    ctl_nxt.tod_flag = trig || (ctl_r.tod_flag && !flag_clr);
    // capture the address phase for the data phase
    ctl_nxt.dp_wr  = addr_ok && hwrite;
    ctl_nxt.dp_idx = addr_idx;
    // read data from next state so a write just before is seen
    if (addr_ok && !hwrite) begin
      ctl_nxt.hrdata = rd_word(addr_idx, ctl_nxt, bak_nxt);
    end else begin
      ctl_nxt.hrdata = 32'h0000_0000;
    end
  end

  // control state, cleared by reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_r <= CTL_RST;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // backed state has no reset so system resets leave it alone
  always_ff @(posedge clk) begin
    bak_r <= bak_nxt;
  end

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = ctl_r.hrdata;
  // event only while alarm enable is set
  assign irq = ctl_r.tod_flag && ctl_r.tod_mask && ctl_r.ade;

  // helper views of address-phase reads
  logic rd_alm_hi;
  logic rd_alm_lo;
  assign rd_alm_hi = addr_ok && !hwrite && (addr_idx == IDX_ALM_HI);
  assign rd_alm_lo = addr_ok && !hwrite && (addr_idx == IDX_ALM_LO);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_high_wr_open: assert property (
    wr_hit(ctl_r, IDX_ALM_HI) && alm_open
    |=> bak_r.alm_hi == $past(hwdata[3:0]))
    else $error("alarm high write lost while allowed");

  a_high_wr_shut: assert property (
    wr_hit(ctl_r, IDX_ALM_HI) && ctl_r.ade && ctl_r.cce
    |=> $stable(bak_r.alm_hi))
    else $error("alarm high changed while locked");

  a_high_rd_any: assert property (
    rd_alm_hi |=> hrdata[3:0] == bak_r.alm_hi)
    else $error("alarm high read mismatch");

  a_high_rsvd_zero: assert property (
    rd_alm_hi |=> hrdata[31:4] == 28'h000_0000)
    else $error("alarm high reserved bits not zero");

  a_low_wr_open: assert property (
    wr_hit(ctl_r, IDX_ALM_LO) && alm_open && !busy
    |=> bak_r.alm_lo == $past(hwdata[15:0]))
    else $error("alarm low write lost while allowed");

  a_low_wr_busy: assert property (
    wr_hit(ctl_r, IDX_ALM_LO) && (busy || !alm_open)
    |=> $stable(bak_r.alm_lo))
    else $error("alarm low changed while locked");

  a_low_rd_any: assert property (
    rd_alm_lo |=> hrdata == {16'h0000, bak_r.alm_lo})
    else $error("alarm low read mismatch");

  a_tod_fire: assert property (
    tick && ctl_r.cce && bak_r.sub == SUB_LAST &&
    {bak_r.alm_hi, bak_r.alm_lo} == sec_inc[19:0]
    |=> ctl_r.tod_flag)
    else $error("alarm did not fire on match at rollover");

  a_tod_only_roll: assert property (
    !ctl_r.tod_flag ##1 ctl_r.tod_flag
    |-> $past(tick && ctl_r.cce && bak_r.sub == SUB_LAST))
    else $error("alarm flag rose outside a rollover");

  a_sub_advance: assert property (
    tick && ctl_r.cce |=> bak_r.sub == $past(bak_r.sub) + 8'h01)
    else $error("subsecond did not advance on tick");

  a_sec_carry: assert property (
    rollover |=> bak_r.sec == $past(bak_r.sec) + 32'h0000_0001)
    else $error("seconds did not advance on rollover");

  // seconds are unknown until first loaded, and loads need the clock off
  a_sec_hold: assert property (
    ctl_r.cce && !rollover &&
    !wr_hit(ctl_r, IDX_SEC_HI) && !wr_hit(ctl_r, IDX_SEC_LO)
    |=> $stable(bak_r.sec))
    else $error("seconds moved without rollover or load");

  a_flag_sticky: assert property (
    ctl_r.tod_flag && !flag_clr |=> ctl_r.tod_flag)
    else $error("alarm flag dropped without clear");

  a_irq_gated: assert property (
    !ctl_r.ade |-> !irq)
    else $error("interrupt raised with alarm disabled");

  a_flag_clear: assert property (
    flag_clr && !trig |=> !ctl_r.tod_flag)
    else $error("alarm flag not cleared by write one");

  a_flag_set_wins: assert property (
    trig |=> ctl_r.tod_flag)
    else $error("alarm flag not set on firing");

  a_no_fire_off: assert property (
    !ctl_r.cce && !ctl_r.tod_flag |=> !ctl_r.tod_flag)
    else $error("alarm fired with clock stopped");

  a_sub_hold: assert property (
    ctl_r.cce && !tick |=> $stable(bak_r.sub))
    else $error("subsecond moved without a tick");

  a_div_step: assert property (
    osc_edge |=> ctl_r.div == $past(ctl_r.div) + 7'h01)
    else $error("divider did not step on oscillator edge");

  a_busy_load: assert property (
    cnt_open && wr_hit(ctl_r, IDX_SUBSEC) |=> ctl_r.busy_cnt == BUSY_CYCLES)
    else $error("busy not raised by counter load");

  a_busy_count: assert property (
    busy |=> ctl_r.busy_cnt == $past(ctl_r.busy_cnt) - 3'h1)
    else $error("busy count did not step down");

  // read data stands only in the data phase
  a_rdata_idle: assert property (
    !(addr_ok && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  c_alarm_fire:   cover property (rollover && trig);
  c_busy_refuse:  cover property (wr_hit(ctl_r, IDX_ALM_LO) && busy);
  c_high_locked:  cover property (wr_hit(ctl_r, IDX_ALM_HI) && !alm_open);
  c_irq_rise:     cover property (!irq ##1 irq);
  c_clear_vs_set: cover property (trig && flag_clr);

endmodule // rtcal_top

`default_nettype wire

/* src/rtcal_pkg.sv */
// shared constants and carriers for the time-of-day alarm block
package rtcal_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_SUBSEC = 6'h1a;
  localparam logic [5:0] IDX_SEC_HI = 6'h1b;
  localparam logic [5:0] IDX_SEC_LO = 6'h1c;
  localparam logic [5:0] IDX_ALM_HI = 6'h1e;
  localparam logic [5:0] IDX_ALM_LO = 6'h1f;
  localparam logic [5:0] IDX_CTRL   = 6'h20;
  localparam logic [5:0] IDX_STAT   = 6'h21;
  localparam logic [5:0] IDX_ISTAT  = 6'h22;
  localparam logic [5:0] IDX_IMASK  = 6'h23;

  // field positions
  localparam int CTRL_CCE_BIT  = 0;
  localparam int CTRL_ADE_BIT  = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int IRQ_TOD_BIT   = 0;

  // 32.768 kHz edges per 256 Hz tick is 128: divider runs 0..127
  localparam logic [6:0] DIV_LAST    = 7'h7f;
  localparam logic [7:0] SUB_LAST    = 8'hff;
  // cycles that a counter load keeps the busy flag up
  localparam logic [2:0] BUSY_CYCLES = 3'h4;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;

  // reset-cleared control state of the block
  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic [6:0]  div;
    logic        cce;
    logic        ade;
    logic [2:0]  busy_cnt;
    logic        tod_flag;
    logic        tod_mask;
    logic        dp_wr;
    logic [5:0]  dp_idx;
    logic [31:0] hrdata;
  } rtcal_ctl_s;

  // battery-backed state, never touched by reset
  typedef struct packed {
    logic [3:0]  alm_hi;
    logic [15:0] alm_lo;
    logic [31:0] sec;
    logic [7:0]  sub;
  } rtcal_bak_s;

  localparam rtcal_ctl_s CTL_RST = '0;

endpackage

/* testbench/rtcal_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcal_top_bench;
  import rtcal_pkg::*;

  logic        clk, sys_rst, osc_32k, hsel, hwrite;
  logic        hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q, s, a, seed, junk;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_errors, total_checks, cyc, k, p;

  rtcal_top DUT (
    .clk(clk), .sys_rst(sys_rst), .osc_32k(osc_32k), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // oscillator sped up so that one 256 Hz tick costs about 2k cycles
  initial begin
    osc_32k = 1'b0;
    #1;
    forever #32 osc_32k = ~osc_32k;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: two alarm passes need well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // one single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0000_00, idx, 2'b00};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd(input string nm, input logic [5:0] idx,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0000_0000, r);
    chk(nm, e, r);
  endtask

  // counter loads hold busy; poll the status bit, not a cycle count
  task automatic wait_idle();
    logic [31:0] r;
    do
      bus(1'b0, IDX_STAT, 32'h0000_0000, r);
    while (r[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic irq_is(input logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // expected read of the alarm high register for a compare value
  function automatic logic [31:0] hi_of(input logic [31:0] v);
    return {28'h0000_000, v[19:16]};
  endfunction

  initial begin
    seed = 32'ha38c4e24;
    hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    s = $random(seed);
    // pass 0: alarm off by three, must stay quiet; pass 1: must fire
    for (p = 0; p < 2; p++) begin
      a = s + 32'h0000_0001 + ((p == 0) ? 32'h0000_0003 : 32'h0000_0000);
      wr(IDX_CTRL, 32'h0000_0000);
      wr(IDX_ALM_HI, {28'hffff_fff, a[19:16]});
      rd("alm_hi", IDX_ALM_HI, hi_of(a));
      wr(IDX_ALM_LO, {16'hffff, a[15:0]});
      wr(IDX_SUBSEC, 32'h0000_00ff);
      wait_idle();
      wr(IDX_SEC_HI, {16'h0000, s[31:16]});
      wait_idle();
      wr(IDX_SEC_LO, {16'h0000, s[15:0]});
      // load just made keeps busy up, so this write must be lost
      junk = $random(seed);
      wr(IDX_ALM_LO, {16'h0000, a[15:0] ^ (junk[15:0] | 16'h0001)});
      rd("alm_lo", IDX_ALM_LO, {16'h0000, a[15:0]});
      wr(IDX_IMASK, 32'h0000_0001);
      wr(IDX_ISTAT, 32'h0000_0001);
      wr(IDX_CTRL, 32'h0000_0003);
      wr(IDX_ALM_HI, ~hi_of(a));
      rd("alm_hi", IDX_ALM_HI, hi_of(a));
      k = 0;
      do begin
        bus(1'b0, IDX_SEC_LO, 32'h0000_0000, q);
        k++;
      end while (k < 3000 && q[15:0] !== s[15:0] + 16'h0001);
      s = s + 32'h0000_0001;
      chk("sec_lo", {16'h0000, s[15:0]}, q);
      rd("sec_hi", IDX_SEC_HI, {16'h0000, s[31:16]});
      repeat (3) @(posedge clk);
      irq_is(p[0]);
      rd("flag", IDX_ISTAT, {31'h0, p[0]});
    end
    // masking, enable gating, sticky flag and its clear
    wr(IDX_IMASK, 32'h0000_0000);
    irq_is(1'b0);
    wr(IDX_IMASK, 32'h0000_0001);
    irq_is(1'b1);
    wr(IDX_CTRL, 32'h0000_0001);
    irq_is(1'b0);
    rd("flag", IDX_ISTAT, 32'h0000_0001);
    wr(IDX_ISTAT, 32'h0000_0001);
    rd("flag", IDX_ISTAT, 32'h0000_0000);
    rd("unmapped", 6'h3f, 32'h0000_0000);
    // a second reset must leave the battery-backed alarm values alone
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd("alm_hi", IDX_ALM_HI, hi_of(a));
    rd("alm_lo", IDX_ALM_LO, {16'h0000, a[15:0]});
    rd("ctrl", IDX_CTRL, 32'h0000_0000);
    irq_is(1'b0);
    test_done();
  end

endmodule // rtcal_top_bench

`default_nettype wire
